// ===== eebc_consts.svh
// Offsets, field positions, reset values and timing counts of the byte access controller
`ifndef EEBC_CONSTS_SVH
`define EEBC_CONSTS_SVH

// Word indices; each register is one word, so its byte address is four times the index
`define EEBC_IDX_CTRL 6'h1c
`define EEBC_IDX_DATA 6'h1d
`define EEBC_IDX_ADDRL 6'h1e
// High address word sits right after the low one
`define EEBC_IDX_ADDRH 6'h1f
`define EEBC_OFF_CTRL ({`EEBC_IDX_CTRL, 2'h0})
`define EEBC_OFF_ADDRL ({`EEBC_IDX_ADDRL, 2'h0})
`define EEBC_OFF_ADDRH ({`EEBC_IDX_ADDRH, 2'h0})
`define EEBC_OFF_DATA ({`EEBC_IDX_DATA, 2'h0})

`define EEBC_BIT_RD 0
`define EEBC_BIT_PS 1
`define EEBC_BIT_ARM 2
`define EEBC_BIT_RIE 3
`define EEBC_BIT_MODE_LO 4
`define EEBC_BIT_MODE_HI 5

`define EEBC_MODE_ATOMIC 2'h0
`define EEBC_MODE_ERASE 2'h1
`define EEBC_MODE_WRITE 2'h2
`define EEBC_MODE_RSVD 2'h3

`define EEBC_DATA_RST 8'h00
`define EEBC_ADDR_RST 9'h000
`define EEBC_ERASED 8'hff
`define EEBC_DEPTH 512

`define EEBC_ATOMIC_US 3400
`define EEBC_SPLIT_US 1800
`define EEBC_OSC_NS 1000
`define EEBC_READ_STALL 3'h4
`define EEBC_PROG_STALL 3'h2
`define EEBC_ARM_WINDOW 3'h4

`endif

// ===== eebc_pkg.sv
// Types shared by the byte access controller modules
package eebc_pkg;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_ADDRL,
    REG_ADDRH,
    REG_DATA,
    REG_NONE
  } eebc_reg_e;

  typedef enum logic {
    ENG_IDLE,
    ENG_RUN
  } eebc_eng_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [8:0] addr;
    logic [7:0] data;
  } eebc_op_s;

endpackage : eebc_pkg

// ===== eebc_nv_array.sv
// Byte-wide nonvolatile array model: read, erase, write-only and combined programming
`include "eebc_consts.svh"
module eebc_nv_array import eebc_pkg::*; (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic op_fire,
  input eebc_op_s op,
  input wire logic [8:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [`EEBC_DEPTH];

  // Contents survive reset, as a real array would
  always_ff @(posedge clk) begin
    if (clk_en && op_fire) begin
      case (op.mode)
        `EEBC_MODE_ATOMIC: mem[op.addr] <= op.data;
        `EEBC_MODE_ERASE: mem[op.addr] <= `EEBC_ERASED;
        // Only clears bits; an unerased byte ends up mixed
        `EEBC_MODE_WRITE: mem[op.addr] <= mem[op.addr] & op.data;
        default: begin
        end
      endcase
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : eebc_nv_array

// ===== eebc_prog_timer.sv
// Programming timer counting ticks of the calibrated oscillator
`include "eebc_consts.svh"
module eebc_prog_timer import eebc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire logic start,
  input wire logic [11:0] ticks,
  output logic done
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic run_q;
  logic [11:0] cnt_q;
  logic rise;

  // Oscillator is asynchronous to pclk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= osc_tick;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cnt_q <= 12'h000;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        run_q <= 1'b1;
        cnt_q <= ticks;
      end else if (run_q && rise) begin
        if (cnt_q <= 12'h001) begin
          run_q <= 1'b0;
          cnt_q <= 12'h000;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 12'h001;
        end
      end
    end
  end

endmodule : eebc_prog_timer

// ===== eebc_ctrl.sv
// APB controller for single-byte read, erase and programming of the data array
`include "eebc_consts.svh"
module eebc_ctrl import eebc_pkg::*; #(
  parameter logic [11:0] FULL_TICKS = 12'(`EEBC_ATOMIC_US * 1000 / `EEBC_OSC_NS),
  parameter logic [11:0] SPLIT_TICKS = 12'(`EEBC_SPLIT_US * 1000 / `EEBC_OSC_NS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic global_irq_enable,
  output logic core_stall,
  output logic ready_irq
);

  function automatic eebc_reg_e reg_sel(input logic [7:0] a);
    case (a)
      `EEBC_OFF_CTRL: reg_sel = REG_CTRL;
      `EEBC_OFF_ADDRL: reg_sel = REG_ADDRL;
      `EEBC_OFF_ADDRH: reg_sel = REG_ADDRH;
      `EEBC_OFF_DATA: reg_sel = REG_DATA;
      default: reg_sel = REG_NONE;
    endcase
  endfunction : reg_sel

  logic [8:0] nv_addr_q;
  logic [7:0] nv_data_q;
  logic [1:0] prog_mode_bits_q;
  logic ready_irq_enable_q;
  logic program_start_bit_q;
  logic [2:0] arm_cnt_q;
  logic [2:0] stall_cnt_q;
  logic [2:0] stall_cnt_d;
  eebc_eng_e eng_q;
  eebc_op_s op_q;
  eebc_op_s op_d;
  logic [7:0] rd_data;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;
  logic wr_done;
  logic wr_ctrl;
  logic lane0;
  logic arm_set;
  logic start_ok;
  logic read_ok;
  logic tmr_done;
  logic [11:0] tmr_ticks;

  // Access completes on the edge where pready is seen high
  assign lane0 = pstrb[0];
  assign wr_done = psel && penable && pready && pwrite && pclken;
  assign wr_ctrl = wr_done && lane0 && (reg_sel(paddr) == REG_CTRL);
  assign arm_set = wr_ctrl && pwdata[`EEBC_BIT_ARM];
  assign start_ok = wr_ctrl && pwdata[`EEBC_BIT_PS] && (arm_cnt_q != 3'h0)
    && !program_start_bit_q && (prog_mode_bits_q != `EEBC_MODE_RSVD);
  assign read_ok = wr_ctrl && pwdata[`EEBC_BIT_RD] && !program_start_bit_q;

  // One wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (pclken) begin
      pready <= psel && penable && !pready;
    end
  end

  assign ctrl_rd = {2'h0, prog_mode_bits_q, ready_irq_enable_q, (arm_cnt_q != 3'h0),
    program_start_bit_q, 1'b0};

  always_comb begin
    case (reg_sel(paddr))
      REG_CTRL: rd_mux = ctrl_rd;
      REG_ADDRL: rd_mux = nv_addr_q[7:0];
      REG_ADDRH: rd_mux = {7'h00, nv_addr_q[8]};
      REG_DATA: rd_mux = nv_data_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pclken) begin
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
        pslverr <= (reg_sel(paddr) == REG_NONE);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Address and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_addr_q <= `EEBC_ADDR_RST;
      nv_data_q <= `EEBC_DATA_RST;
    end else if (pclken) begin
      if (read_ok) begin
        nv_data_q <= rd_data;
      end else if (wr_done && lane0) begin
        case (reg_sel(paddr))
          REG_ADDRL: nv_addr_q[7:0] <= pwdata[7:0];
          REG_ADDRH: nv_addr_q[8] <= pwdata[0];
          REG_DATA: nv_data_q <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_irq_enable_q <= 1'b0;
    end else if (pclken && wr_ctrl) begin
      ready_irq_enable_q <= pwdata[`EEBC_BIT_RIE];
    end
  end

  // Arm window; a fresh arm write restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_q <= 3'h0;
    end else if (pclken) begin
      if (arm_set) begin
        arm_cnt_q <= `EEBC_ARM_WINDOW;
      end else if (start_ok) begin
        arm_cnt_q <= 3'h0;
      end else if (arm_cnt_q != 3'h0) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // Mode survives a bus reset that lands mid-programming
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      prog_mode_bits_q <= `EEBC_MODE_ATOMIC;
    end else if (pclken) begin
      if (!presetn) begin
        if (!program_start_bit_q) begin
          prog_mode_bits_q <= `EEBC_MODE_ATOMIC;
        end
      end else if (wr_ctrl && !program_start_bit_q) begin
        prog_mode_bits_q <= pwdata[`EEBC_BIT_MODE_HI:`EEBC_BIT_MODE_LO];
      end
    end
  end

  // Core stall counter
  always_comb begin
    stall_cnt_d = stall_cnt_q;
    if (read_ok) begin
      stall_cnt_d = `EEBC_READ_STALL;
    end else if (start_ok) begin
      stall_cnt_d = `EEBC_PROG_STALL;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_q <= 3'h0;
      core_stall <= 1'b0;
    end else if (pclken) begin
      stall_cnt_q <= stall_cnt_d;
      core_stall <= (stall_cnt_d != 3'h0);
    end
  end

  // Programming engine runs on power-on reset so a started byte completes
  always_comb begin
    op_d.mode = prog_mode_bits_q;
    op_d.addr = nv_addr_q;
    op_d.data = nv_data_q;
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      eng_q <= ENG_IDLE;
      program_start_bit_q <= 1'b0;
      op_q <= '0;
    end else if (pclken) begin
      case (eng_q)
        ENG_IDLE: begin
          if (start_ok && presetn) begin
            op_q <= op_d;
            program_start_bit_q <= 1'b1;
            eng_q <= ENG_RUN;
          end
        end
        ENG_RUN: begin
          if (tmr_done) begin
            program_start_bit_q <= 1'b0;
            eng_q <= ENG_IDLE;
          end
        end
        default: begin
          eng_q <= ENG_IDLE;
        end
      endcase
    end
  end

  assign tmr_ticks = (prog_mode_bits_q == `EEBC_MODE_ATOMIC) ? FULL_TICKS
    : SPLIT_TICKS;

  eebc_prog_timer u_timer (
    .clk(pclk),
    .rst_n(por_n),
    .clk_en(pclken),
    .osc_tick(osc_tick),
    .start(start_ok && presetn),
    .ticks(tmr_ticks),
    .done(tmr_done)
  );

  // Array update lands at the end of the timed period
  eebc_nv_array u_array (
    .clk(pclk),
    .clk_en(pclken),
    .op_fire(tmr_done && (eng_q == ENG_RUN)),
    .op(op_q),
    .rd_addr(nv_addr_q),
    .rd_data(rd_data)
  );

  // Level interrupt, no flag to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_irq <= 1'b0;
    end else if (pclken) begin
      ready_irq <= ready_irq_enable_q && global_irq_enable && !program_start_bit_q;
    end
  end

endmodule : eebc_ctrl

// ===== eebc_ctrl_properties.sv
// Checker of bus timing, stall lengths and read-back fields
`include "eebc_consts.svh"
module eebc_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic core_stall,
  input wire logic ready_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite;
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_answer_owned: assert property (pready |-> psel && penable)
    else $error("pready without access");
  a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {`EEBC_OFF_CTRL,
    `EEBC_OFF_ADDRL, `EEBC_OFF_ADDRH, `EEBC_OFF_DATA}))
    else $error("pslverr wrong");
  a_high_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data set");
  a_ctrl_fields: assert property (rd_ok && paddr == `EEBC_OFF_CTRL |->
    prdata[7:6] == 2'h0 && !prdata[0])
    else $error("control fixed bits set");
  a_addrh_width: assert property (rd_ok && paddr == `EEBC_OFF_ADDRH |->
    prdata[7:1] == 7'h0)
    else $error("address high too wide");
  a_stall_len: assert property ($rose(core_stall) |-> core_stall[*2] ##1
    (!core_stall or core_stall[*2] ##1 !core_stall))
    else $error("stall length wrong");
  a_irq_gate: assert property (ready_irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  cover property ($rose(core_stall));
  cover property (pready && pslverr);
  cover property (ready_irq);
endmodule : eebc_ctrl_properties

// ===== eebc_core_model.sv
// Core side model issuing bus transfers, held off while the core is stalled
module eebc_core_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic core_stall,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // Last low keeps psel up so arm and start go back to back
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic last, output logic [7:0] rd, output logic err);
    while (core_stall) @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    penable <= 1'b0;
    if (last) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer
endmodule : eebc_core_model

// ===== tb_eebc_ctrl.sv
// Bench for byte programming, reads, refusals and resets against a byte model
`include "eebc_consts.svh"
module tb_eebc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] FT = 12'h00c;
  localparam logic [11:0] ST = 12'h006;
  logic pclk, presetn, por_n, osc_tick, gie, psel, penable, pwrite, pready, pslverr;
  logic core_stall, ready_irq, err, gie_d;
  logic [7:0] paddr, rd, d;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pstrb;
  logic [8:0] a;
  logic [1:0] m;
  logic [1:0] seq [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] mem [int];
  int err_count, n_checks, cyc, ticks, t0, n, tt, seed;
  eebc_ctrl #(.FULL_TICKS(FT), .SPLIT_TICKS(ST)) i_eebc_ctrl (.pclk, .presetn, .por_n,
    .pclken(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .osc_tick, .global_irq_enable(gie), .core_stall, .ready_irq);
  eebc_core_model u_core (.pclk, .pready, .pslverr, .prdata, .core_stall, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb);
  always #20 pclk = ~pclk;
  // A 210 ns half period keeps rising oscillator edges off the bus clock grid; falling edges land on pclk edges
  always #210 osc_tick = ~osc_tick;
  always @(posedge osc_tick) ticks++;
  always @(posedge pclk) gie <= 1'($random(seed));
  // Global enable as the design sampled it one edge ago
  always @(posedge pclk) gie_d <= gie;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] dv, input logic last = 1'b1);
    rnd = $random(seed);
    u_core.xfer(1'b1, ad, {rnd[31:8], dv}, last, rd, err);
  endtask : wr
  task automatic rdr(input logic [7:0] ad);
    u_core.xfer(1'b0, ad, 32'h0, 1'b1, rd, err);
  endtask : rdr
  task automatic prog(input logic [1:0] md);
    wr(`EEBC_OFF_CTRL, {2'h0, md, 4'h8});
    wr(`EEBC_OFF_ADDRL, a[7:0]);
    wr(`EEBC_OFF_ADDRH, {7'h00, a[8]});
    wr(`EEBC_OFF_DATA, d);
    wr(`EEBC_OFF_CTRL, {2'h0, md, 4'hc}, 1'b0);
    wr(`EEBC_OFF_CTRL, {2'h0, md, 4'ha});
    t0 = ticks;
  endtask : prog
  task automatic rd_byte;
    wr(`EEBC_OFF_ADDRL, a[7:0]);
    wr(`EEBC_OFF_ADDRH, {7'h00, a[8]});
    wr(`EEBC_OFF_CTRL, {2'h0, m, 4'h9});
    rdr(`EEBC_OFF_DATA);
  endtask : rd_byte
  task automatic wait_idle;
    rdr(`EEBC_OFF_CTRL);
    while (rd[1] === 1'b1) rdr(`EEBC_OFF_CTRL);
    n = ticks - t0;
  endtask : wait_idle
  task automatic rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    por_n = 1'b0;
    osc_tick = 1'b0;
    gie = 1'b0;
    seed = 32'h7dbb9fb9;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    rdr(`EEBC_OFF_DATA);
    chk(rd, `EEBC_DATA_RST);
    u_core.pstrb <= 4'he;
    wr(`EEBC_OFF_DATA, 8'h5a);
    u_core.pstrb <= 4'hf;
    rdr(`EEBC_OFF_DATA);
    chk(rd, `EEBC_DATA_RST);
    rdr(8'h10);
    chk({rd[7:1], err}, 8'h01);
    for (int j = 0; j < 9; j++) begin
      m = seq[j % 3];
      if (j % 3 == 0) a = 9'($random(seed));
      d = 8'($random(seed));
      prog(m);
      rdr(`EEBC_OFF_CTRL);
      chk(8'(rd[1]), 8'h01);
      chk(8'(ready_irq), 8'h00);
      wr(`EEBC_OFF_CTRL, {2'h0, ~m, 4'h8});
      rdr(`EEBC_OFF_CTRL);
      chk(8'(rd[5:4]), 8'(m));
      wr(`EEBC_OFF_DATA, ~d);
      wr(`EEBC_OFF_CTRL, {2'h0, m, 4'h9});
      rdr(`EEBC_OFF_DATA);
      chk(rd, ~d);
      wait_idle();
      chk(8'(ready_irq), 8'(gie_d));
      tt = (m == 2'h0) ? FT : ST;
      chk(8'(n >= tt - 1 && n <= tt + 1), 8'h01);
      mem[a] = (m == 2'h1) ? 8'hff : (m == 2'h2) ? mem[a] & d : d;
      rd_byte();
      chk(rd, mem[a]);
    end
    wr(`EEBC_OFF_CTRL, 8'h04);
    rdr(`EEBC_OFF_CTRL);
    chk(8'(rd[2]), 8'h01);
    wr(`EEBC_OFF_CTRL, 8'h02);
    rdr(`EEBC_OFF_CTRL);
    chk(8'(rd[2:1]), 8'h00);
    prog(2'h3);
    rdr(`EEBC_OFF_CTRL);
    chk(8'(rd[1]), 8'h00);
    prog(2'h1);
    mem[a] = 8'hff;
    rst();
    rdr(`EEBC_OFF_CTRL);
    chk(8'(rd[5:1]), 8'h09);
    wait_idle();
    rst();
    rdr(`EEBC_OFF_CTRL);
    chk(8'(rd[5:4]), 8'h00);
    m = 2'h0;
    rd_byte();
    chk(rd, mem[a]);
    complete_run();
  end
endmodule : tb_eebc_ctrl

bind eebc_ctrl eebc_ctrl_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .global_irq_enable, .core_stall, .ready_irq);
